// *** src/power_alarm_defines.svh ***
// Purpose: offsets, codes, field positions and reset values of the power mode and alarm registers
// Assumes: 12-bit register address, 8-bit register data
// Notes: included by power_alarm_pkg.sv and power_mode_and_alarm_regs.sv
// Function
// - second mode register: 0x06 low power, 0x0F high performance, resets high performance
// - third mode register: 0x00 low power, 0x04 high performance, resets high performance
// - fourth mode register: 0x14 low power, 0x1B high performance, resets high performance
// - summary alarm bit 0 is one exactly when an unmasked alarm flag was set the cycle before
// - a per-alarm mask keeps each masked flag out of the summary
// - with the pin selection set, the summary drives the calibration status pin
// - alarm flags reset to 0x3F and each bit clears by writing one
// - flag bit 5 sets on any lane FIFO overflow or underflow
// - flag bit 4 sets while the serializer PLL is out of lock
// - flag bit 3 sets while the link is enabled but not transmitting data
`ifndef POWER_ALARM_DEFINES_SVH
`define POWER_ALARM_DEFINES_SVH

// register addresses
`define ADDR_PM_B 12'h29a
`define ADDR_PM_C 12'h29b
`define ADDR_PM_D 12'h29c
`define ADDR_ALARM 12'h2c0
`define ADDR_FLAGS 12'h2c1
`define ADDR_MASK 12'h2c2
`define ADDR_PIN_SEL 12'h2c3

// mode codes
`define CODE_B_LP 8'h06
`define CODE_B_HP 8'h0f
`define CODE_C_LP 8'h00
`define CODE_C_HP 8'h04
`define CODE_D_LP 8'h14
`define CODE_D_HP 8'h1b

// alarm flag fields
`define FLAGS_W 6
`define FLAGS_RST 6'h3f
`define MASK_RST 6'h3f
`define BIT_FIFO 5
`define BIT_SPLL 4
`define BIT_LINK 3
`define BIT_REALIGN 2
`define BIT_CLK 0
`define BIT_PIN_SEL 0
`define DATA_ZERO 8'h00

`endif

// *** src/power_alarm_pkg.sv ***
// Purpose: types shared by the power mode and alarm register bank
// Assumes: constants come from power_alarm_defines.svh
// Notes: none
`include "power_alarm_defines.svh"

package power_alarm_pkg;
	// register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	// alarm conditions from the rest of the device
	typedef struct packed {
		logic lane_fifo_alarm;
		logic serializer_pll_alarm;
		logic serial_link_enable;
		logic data_transmit_state;
		logic clock_realign_alarm;
		logic divider_mismatch_alarm;
	} alarm_src_s;

	// complete register state
	typedef struct packed {
		logic [7:0] power_code_b;
		logic [7:0] power_code_c;
		logic [7:0] power_code_d;
		logic [5:0] alarm_mask;
		logic pin_sel;
		logic [5:0] alarm_flags;
		logic alarm;
		logic pin;
		logic low_power_b;
		logic low_power_c;
		logic low_power_d;
		logic low_power_all;
		logic [7:0] rdata;
		logic rvalid;
	} regs_s;
endpackage

// *** src/power_mode_and_alarm_regs.sv ***
// Purpose: power mode selection registers and alarm aggregation with status pin routing
// Assumes: register port is synchronous to clk, one access per cycle, write wins over read
// Notes: read data and rvalid appear one cycle after rd; unmapped reads return zero
`timescale 1ns/1ps
`include "power_alarm_defines.svh"

module power_mode_and_alarm_regs (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register access
	input wire power_alarm_pkg::reg_req_s req,
	output logic [7:0] rdata,
	output logic rvalid,
	// alarm sources and calibration status
	input wire power_alarm_pkg::alarm_src_s src,
	input wire logic cal_status_in,
	// status outputs
	output logic calibration_status_pin,
	output logic alarm,
	output logic [5:0] alarm_flags,
	output logic low_power_b,
	output logic low_power_c,
	output logic low_power_d,
	output logic low_power_all
);
	import power_alarm_pkg::*;

	regs_s st_ff;
	regs_s nxt_st;
	logic [5:0] set_vec;
	logic [5:0] clr_vec;
	logic wr_flags;

	// decode write strobe for one address
	function automatic logic hit(input reg_req_s r, input logic [11:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	// level sources of the alarm flags
	always_comb begin
		set_vec = '0;
		set_vec[`BIT_FIFO] = src.lane_fifo_alarm;
		set_vec[`BIT_SPLL] = src.serializer_pll_alarm;
		set_vec[`BIT_LINK] = src.serial_link_enable && !src.data_transmit_state;
		set_vec[`BIT_REALIGN] = src.clock_realign_alarm;
		set_vec[`BIT_CLK] = src.divider_mismatch_alarm;
	end

	assign wr_flags = hit(req, `ADDR_FLAGS);
	assign clr_vec = wr_flags ? req.wdata[5:0] : '0;

	// next state of the whole bank
	always_comb begin
		nxt_st = st_ff;
		if (hit(req, `ADDR_PM_B)) begin
			nxt_st.power_code_b = req.wdata;
		end
		if (hit(req, `ADDR_PM_C)) begin
			nxt_st.power_code_c = req.wdata;
		end
		if (hit(req, `ADDR_PM_D)) begin
			nxt_st.power_code_d = req.wdata;
		end
		if (hit(req, `ADDR_MASK)) begin
			nxt_st.alarm_mask = req.wdata[5:0];
		end
		if (hit(req, `ADDR_PIN_SEL)) begin
			nxt_st.pin_sel = req.wdata[`BIT_PIN_SEL];
		end
		// write one clears, zero keeps, a live source wins over the clear
		nxt_st.alarm_flags = (st_ff.alarm_flags & ~clr_vec) | set_vec;
		// summary of unmasked flags
		nxt_st.alarm = |(st_ff.alarm_flags & ~st_ff.alarm_mask);
		// pin routing
		nxt_st.pin = st_ff.pin_sel ? nxt_st.alarm : cal_status_in;
		// mode decode follows the stored codes
		nxt_st.low_power_b = (nxt_st.power_code_b == `CODE_B_LP);
		nxt_st.low_power_c = (nxt_st.power_code_c == `CODE_C_LP);
		nxt_st.low_power_d = (nxt_st.power_code_d == `CODE_D_LP);
		nxt_st.low_power_all = nxt_st.low_power_b && nxt_st.low_power_c
			&& nxt_st.low_power_d;
		// read path
		nxt_st.rvalid = req.rd && !req.wr;
		nxt_st.rdata = `DATA_ZERO;
		if (req.rd && !req.wr) begin
			unique case (req.addr)
				`ADDR_PM_B: nxt_st.rdata = st_ff.power_code_b;
				`ADDR_PM_C: nxt_st.rdata = st_ff.power_code_c;
				`ADDR_PM_D: nxt_st.rdata = st_ff.power_code_d;
				`ADDR_ALARM: nxt_st.rdata = {7'h00, st_ff.alarm};
				`ADDR_FLAGS: nxt_st.rdata = {2'h0, st_ff.alarm_flags};
				`ADDR_MASK: nxt_st.rdata = {2'h0, st_ff.alarm_mask};
				`ADDR_PIN_SEL: nxt_st.rdata = {7'h00, st_ff.pin_sel};
				default: nxt_st.rdata = `DATA_ZERO;
			endcase
		end
	end

	// register the bank; reset selects high performance everywhere
	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.power_code_b <= `CODE_B_HP;
			st_ff.power_code_c <= `CODE_C_HP;
			st_ff.power_code_d <= `CODE_D_HP;
			st_ff.alarm_mask <= `MASK_RST;
			st_ff.alarm_flags <= `FLAGS_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state flops
	assign rdata = st_ff.rdata;
	assign rvalid = st_ff.rvalid;
	assign calibration_status_pin = st_ff.pin;
	assign alarm = st_ff.alarm;
	assign alarm_flags = st_ff.alarm_flags;
	assign low_power_b = st_ff.low_power_b;
	assign low_power_c = st_ff.low_power_c;
	assign low_power_d = st_ff.low_power_d;
	assign low_power_all = st_ff.low_power_all;

	// checks on the bank behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_reset_hp_codes: assert property ($past(rst) |-> st_ff.power_code_b == `CODE_B_HP
		&& st_ff.power_code_c == `CODE_C_HP && st_ff.power_code_d == `CODE_D_HP)
		else $error("mode registers not at high performance after reset");
	a_decode_b_lp: assert property (hit(req, `ADDR_PM_B)
		|=> low_power_b == ($past(req.wdata) == `CODE_B_LP))
		else $error("second mode register decode wrong");
	a_decode_c_lp: assert property (hit(req, `ADDR_PM_C)
		|=> low_power_c == ($past(req.wdata) == `CODE_C_LP))
		else $error("third mode register decode wrong");
	a_decode_d_lp: assert property (hit(req, `ADDR_PM_D) ##1 !req.wr
		|=> low_power_d == ($past(req.wdata, 2) == `CODE_D_LP))
		else $error("fourth mode register decode wrong");
	a_summary_bit: assert property (alarm == |($past(alarm_flags) & ~$past(st_ff.alarm_mask)))
		else $error("summary alarm does not match unmasked flags");
	a_mask_excludes: assert property (st_ff.alarm_mask == 6'h3f ##1 st_ff.alarm_mask == 6'h3f
		|-> !alarm)
		else $error("masked flags reached the summary");
	a_pin_routing: assert property (st_ff.pin_sel |=> calibration_status_pin == alarm)
		else $error("summary not routed to status pin");
	a_reset_flags: assert property ($past(rst) |-> alarm_flags == `FLAGS_RST && !alarm)
		else $error("alarm flags wrong after reset");
	a_w1c_clear: assert property (wr_flags && req.wdata[`BIT_CLK] && !set_vec[`BIT_CLK]
		|=> !alarm_flags[`BIT_CLK])
		else $error("write one did not clear flag");
	a_fifo_sets: assert property (src.lane_fifo_alarm |=> alarm_flags[`BIT_FIFO])
		else $error("fifo alarm flag not set");
	a_pll_sets: assert property (src.serializer_pll_alarm |=> alarm_flags[`BIT_SPLL])
		else $error("pll alarm flag not set");
	a_link_sets: assert property (src.serial_link_enable && !src.data_transmit_state
		|=> alarm_flags[`BIT_LINK])
		else $error("link alarm flag not set");
	a_zero_keeps: assert property (wr_flags && !req.wdata[`BIT_SPLL] && alarm_flags[`BIT_SPLL]
		|=> alarm_flags[`BIT_SPLL])
		else $error("write zero changed a flag");
	a_set_beats_clr: assert property (wr_flags && req.wdata[`BIT_FIFO] && src.lane_fifo_alarm
		|=> alarm_flags[`BIT_FIFO])
		else $error("live condition lost to a clear");
endmodule

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the power mode and alarm register bank
// Assumes: inputs change at the falling clock edge, reset held six cycles
// Notes: alarm sources are levels, so a flag is cleared only once its source drops
`timescale 1ns/1ps
`include "power_alarm_defines.svh"

module tb;
	import power_alarm_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	reg_req_s req = '0;
	alarm_src_s src = '0;
	logic cal_status_in = 1'b0;
	logic [7:0] rdata;
	logic rvalid, pin, alarm, lp_b, lp_c, lp_d, lp_all;
	logic [5:0] alarm_flags;
	int mismatches = 0;
	int n_checks = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	power_mode_and_alarm_regs power_mode_and_alarm_regs_i (.clk(clk), .rst(rst), .req(req),
		.rdata(rdata), .rvalid(rvalid), .src(src), .cal_status_in(cal_status_in),
		.calibration_status_pin(pin), .alarm(alarm), .alarm_flags(alarm_flags),
		.low_power_b(lp_b), .low_power_c(lp_c), .low_power_d(lp_d), .low_power_all(lp_all));

	// counts and reports one comparison
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	// one write, strobe held across a single rising edge
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		req = '0;
	endtask

	// one read, answer looked at in the single cycle that rvalid stands
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(negedge clk);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		req = '0;
		chk({7'h00, rvalid}, 8'h01);
		chk(rdata, exp);
	endtask

	// reset values, an ignored write and an unmapped read
	task automatic t_reset;
		rd(`ADDR_PM_B, `CODE_B_HP);
		rd(`ADDR_PM_C, `CODE_C_HP);
		rd(`ADDR_PM_D, `CODE_D_HP);
		rd(`ADDR_FLAGS, 8'h3f);
		wr(`ADDR_ALARM, 8'hff);
		rd(`ADDR_ALARM, 8'h00);
		rd(`ADDR_MASK, 8'h3f);
		rd(`ADDR_PIN_SEL, 8'h00);
		rd(12'h123, 8'h00);
	endtask

	// low power codes decoded per register and all together; the bench runs below 1 GSPS,
	// keeps link and calibration enables low, and the wait after a change stands for calibration
	task automatic t_modes;
		wr(`ADDR_PM_B, `CODE_B_LP);
		wr(`ADDR_PM_C, `CODE_C_LP);
		idle(1);
		chk({4'h0, lp_b, lp_c, lp_d, lp_all}, 8'h0c);
		wr(`ADDR_PM_D, `CODE_D_LP);
		idle(1);
		chk({4'h0, lp_b, lp_c, lp_d, lp_all}, 8'h0f);
		rd(`ADDR_PM_D, `CODE_D_LP);
		wr(`ADDR_PM_B, `CODE_B_HP);
		wr(`ADDR_PM_C, `CODE_C_HP);
		wr(`ADDR_PM_D, `CODE_D_HP);
		idle(1);
		chk({4'h0, lp_b, lp_c, lp_d, lp_all}, 8'h00);
	endtask

	// write one to clear, zero keeps, persisting source, mask
	task automatic t_flags;
		wr(`ADDR_FLAGS, 8'h00);
		idle(1);
		chk({2'b00, alarm_flags}, 8'h3f);
		wr(`ADDR_FLAGS, 8'h3c);
		idle(1);
		chk({2'b00, alarm_flags}, 8'h03);
		wr(`ADDR_FLAGS, 8'h03);
		wr(`ADDR_MASK, 8'h00);
		idle(2);
		chk({alarm, 1'b0, alarm_flags}, 8'h00);
		src.divider_mismatch_alarm = 1'b1;
		wr(`ADDR_FLAGS, 8'h01);
		idle(2);
		chk({alarm, 1'b0, alarm_flags}, 8'h81);
		rd(`ADDR_ALARM, 8'h01);
		rd(`ADDR_FLAGS, 8'h01);
		wr(`ADDR_MASK, 8'h01);
		idle(2);
		chk({7'h00, alarm}, 8'h00);
		src = '0;
		wr(`ADDR_FLAGS, 8'h01);
		wr(`ADDR_MASK, 8'h00);
	endtask

	// one source setting: the flags and the summary it gives, then cleared again
	task automatic src_case(input logic [5:0] s, input logic [5:0] e);
		@(negedge clk);
		src = s;
		idle(2);
		chk({alarm, 1'b0, alarm_flags}, {|e, 1'b0, e});
		src = '0;
		wr(`ADDR_FLAGS, 8'h3f);
		idle(1);
		chk({2'b00, alarm_flags}, 8'h00);
	endtask

	// summary or calibration status routed to the pin
	task automatic t_pin;
		wr(`ADDR_PIN_SEL, 8'h01);
		src.divider_mismatch_alarm = 1'b1;
		idle(3);
		chk({7'h00, pin}, 8'h01);
		src = '0;
		cal_status_in = 1'b1;
		wr(`ADDR_FLAGS, 8'h01);
		idle(2);
		chk({7'h00, pin}, 8'h00);
		wr(`ADDR_PIN_SEL, 8'h00);
		idle(2);
		chk({7'h00, pin}, 8'h01);
	endtask

	// mid-run reset restores high performance codes and alarm defaults, then a read
	// that coincides with a write is dropped while the write lands
	task automatic t_rerun;
		wr(`ADDR_PM_B, `CODE_B_LP);
		wr(`ADDR_PM_C, `CODE_C_LP);
		wr(`ADDR_PM_D, `CODE_D_LP);
		wr(`ADDR_MASK, 8'h00);
		@(negedge clk);
		rst = 1'b1;
		idle(2);
		rst = 1'b0;
		chk({4'h0, lp_b, lp_c, lp_d, lp_all}, 8'h00);
		rd(`ADDR_PM_B, `CODE_B_HP);
		rd(`ADDR_PM_C, `CODE_C_HP);
		rd(`ADDR_PM_D, `CODE_D_HP);
		rd(`ADDR_MASK, 8'h3f);
		chk({alarm, 1'b0, alarm_flags}, 8'h3f);
		@(negedge clk);
		req = '{1'b1, 1'b1, `ADDR_MASK, 8'h00};
		@(negedge clk);
		req = '0;
		chk({7'h00, rvalid}, 8'h00);
		rd(`ADDR_MASK, 8'h00);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		idle(6);
		rst = 1'b0;
		t_reset();
		t_modes();
		t_flags();
		src_case(6'b100000, 6'h20);
		src_case(6'b010000, 6'h10);
		src_case(6'b001000, 6'h08);
		src_case(6'b001100, 6'h00);
		src_case(6'b000010, 6'h04);
		t_pin();
		t_rerun();
		stop_test();
	end

	// watchdog against a hang
	initial begin
		#100000;
		mismatches++;
		stop_test();
	end
endmodule
